/* File: core/sbl_pkg.sv */
// constants and types shared by the serial boot loader
package sbl_pkg;
    // ************************************************************
    // link timing
    // ************************************************************
    localparam int CLK_HZ = 250_000_000;
    localparam int BAUD_DEFAULT = 7812;
    localparam int BIT_CYC = CLK_HZ / BAUD_DEFAULT;
    localparam int HALF_DIV = 2;
    localparam int CNT_W = 16;
    localparam int CHAR_BITS = 10;
    localparam int DATA_BITS = 8;
    localparam int IDLE_CHARS = 4;
    localparam int IDLE_BITS = IDLE_CHARS * CHAR_BITS;
    localparam int IDLE_W = 6;
    localparam int BIT_W = 4;

    // ************************************************************
    // download sizes
    // ************************************************************
    localparam int FIXED_LEN_BYTES = 256;
    localparam int RAM_BYTES_DEF = 512;
    localparam int ADDR_W = 11;
    localparam int FIFO_DEPTH = 8;

    // ************************************************************
    // characters and jump targets
    // ************************************************************
    localparam logic [7:0] CHAR_ZERO = 8'h00;
    localparam logic [7:0] CHAR_SYNC = 8'h55;
    localparam logic [7:0] CHAR_RATE = 8'hFF;
    localparam logic [15:0] EE_START = 16'hB600;
    localparam logic [15:0] RAM_START = 16'h0;

    // boot sequence, gray along break-wait-load-flush-jump
    typedef enum logic [2:0] {
        SBL_BREAK = 3'b000,
        SBL_WAIT = 3'b001,
        SBL_LOAD = 3'b011,
        SBL_FLUSH = 3'b010,
        SBL_JUMP = 3'b110
    } sbl_state_t;
endpackage

/* File: core/sbl_boot_loader.sv */
// serial boot loader: receive fifo and boot sequence top
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - first char zero or break jumps to erasable memory start, no download.
// - first char hex 55 jumps to RAM start; host sends at default rate.
// - variable length, rate char alone ends load after four chars, RAM jump.
// - line idle four character times ends variable-length download.
// - fixed-length download is exactly 256 data bytes after rate char.
// - idle detect armed only after rate char; wait forever before it.
// - receiver starts only on high-to-low edge; stuck-low line gives nothing.
// - one break character is transmitted when the sequence starts.
// - transmit pin is open drain: pulls low, never drives high.
// - received bytes are programmed into on-chip memory.
// - each byte written to memory is also sent back to the host over the link.
// - serial receive, transmit and pins enabled before first char.
// - every download byte below the ram limit that enters the fifo is echoed back on transmit.

// ****************************************************************
// receive fifo
// ****************************************************************
module sbl_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);
    typedef struct packed {
        logic [PW:0] wr;
        logic [PW:0] rd;
    } sbl_fifo_t;
    sbl_fifo_t q_reg;
    sbl_fifo_t q_next;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push;
    logic pop;

    // full when pointers differ only in the wrap bit
    assign in_ready = !((q_reg.wr[PW] != q_reg.rd[PW]) &&
                        (q_reg.wr[PW-1:0] == q_reg.rd[PW-1:0]));
    assign out_valid = (q_reg.wr != q_reg.rd);
    assign out_data = mem[q_reg.rd[PW-1:0]];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // pointer update
    always_comb begin
        q_next = q_reg;
        if (push) begin
            q_next.wr = q_reg.wr + 1'b1;
        end
        if (pop) begin
            q_next.rd = q_reg.rd + 1'b1;
        end
    end

    // storage is written without reset, it holds data only
    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[q_reg.wr[PW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            q_reg <= '0;
        end else begin
            q_reg <= q_next;
        end
    end
endmodule // sbl_fifo

// ****************************************************************
// boot sequence top
// ****************************************************************
module sbl_boot_loader #(
    parameter int BIT_CYCLES = sbl_pkg::BIT_CYC,
    parameter bit FIXED_LEN = 1'b0,
    parameter int LOAD_LEN = sbl_pkg::FIXED_LEN_BYTES,
    parameter int RAM_BYTES = sbl_pkg::RAM_BYTES_DEF
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // serial pins
    input wire logic rxd_in,
    output logic txd_out,
    output logic txd_oe,
    // serial unit owns the pins
    output logic serial_en,
    // ram write port
    output logic ram_we,
    output logic [sbl_pkg::ADDR_W-1:0] ram_addr,
    output logic [7:0] ram_wdata,
    // jump request and status
    output logic jump_valid,
    output logic [15:0] jump_addr,
    output logic load_overrun
);
    localparam logic [15:0] BIT_C = 16'(BIT_CYCLES - 1);
    localparam logic [15:0] HALF_C = 16'(BIT_CYCLES / sbl_pkg::HALF_DIV);
    localparam logic [3:0] LAST_BIT = 4'(sbl_pkg::CHAR_BITS - 1);
    localparam logic [5:0] IDLE_END = 6'(sbl_pkg::IDLE_BITS);
    localparam logic [10:0] LEN_C = 11'(LOAD_LEN);
    localparam logic [10:0] RAM_C = 11'(RAM_BYTES);

    typedef struct packed {
        sbl_pkg::sbl_state_t st;
        logic s1;
        logic s2;
        logic high;
        logic rx_busy;
        logic [15:0] rx_cnt;
        logic [3:0] rx_bit;
        logic [7:0] rx_sh;
        logic rx_valid;
        logic rx_brk;
        logic [7:0] rx_data;
        logic tx_busy;
        logic [15:0] tx_cnt;
        logic [3:0] tx_bit;
        logic [9:0] tx_sh;
        logic txd_oe;
        logic [15:0] idle_cnt;
        logic [5:0] idle_bits;
        logic armed;
        logic [10:0] count;
        logic [10:0] wr_idx;
        logic ram_we;
        logic [10:0] ram_addr;
        logic [7:0] ram_wdata;
        logic jump_valid;
        logic [15:0] jump_addr;
        logic serial_en;
        logic overrun;
    } sbl_regs_t;

    sbl_regs_t q_reg;
    sbl_regs_t q_next;
    logic f_in_valid;
    logic f_in_ready;
    logic f_out_valid;
    logic f_out_ready;
    logic [7:0] f_out_data;

    // bytes wait here while the echo of an earlier one is still shifting
    sbl_fifo #(.WIDTH(sbl_pkg::DATA_BITS), .DEPTH(sbl_pkg::FIFO_DEPTH)) u_fifo (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .in_valid(f_in_valid),
        .in_ready(f_in_ready),
        .in_data(q_reg.rx_data),
        .out_valid(f_out_valid),
        .out_ready(f_out_ready),
        .out_data(f_out_data)
    );

    // accept while loading and below the ram limit
    assign f_in_valid = q_reg.rx_valid && (q_reg.st == sbl_pkg::SBL_LOAD) &&
                        (q_reg.count < RAM_C);
    // drain only when the transmitter is free, so echo stalls the fifo
    assign f_out_ready = !q_reg.tx_busy && !q_reg.ram_we;

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        q_next = q_reg;
        q_next.rx_valid = 1'b0;
        q_next.ram_we = 1'b0;
        q_next.s1 = rxd_in;
        q_next.s2 = q_reg.s1;
        // line must be seen high before a start edge counts
        if (q_reg.s2) begin
            q_next.high = 1'b1;
        end
        if (!q_reg.rx_busy) begin
            if (q_reg.high && !q_reg.s2) begin
                q_next.rx_busy = 1'b1;
                q_next.high = 1'b0;
                q_next.rx_cnt = HALF_C;
                q_next.rx_bit = '0;
            end
        end else if (q_reg.rx_cnt != '0) begin
            q_next.rx_cnt = q_reg.rx_cnt - 1'b1;
        end else begin
            q_next.rx_cnt = BIT_C;
            q_next.rx_bit = q_reg.rx_bit + 1'b1;
            if (q_reg.rx_bit == '0) begin
                q_next.rx_busy = !q_reg.s2; // false start aborts
            end else if (q_reg.rx_bit == LAST_BIT) begin
                q_next.rx_busy = 1'b0;
                q_next.rx_valid = 1'b1;
                q_next.rx_data = q_reg.rx_sh;
                q_next.rx_brk = !q_reg.s2 && (q_reg.rx_sh == sbl_pkg::CHAR_ZERO);
            end else begin
                q_next.rx_sh = {q_reg.s2, q_reg.rx_sh[7:1]};
            end
        end
        // transmitter: pin only ever pulled low
        if (q_reg.tx_busy) begin
            if (q_reg.tx_cnt != '0) begin
                q_next.tx_cnt = q_reg.tx_cnt - 1'b1;
            end else begin
                q_next.tx_cnt = BIT_C;
                q_next.tx_sh = {1'b1, q_reg.tx_sh[9:1]};
                q_next.tx_bit = q_reg.tx_bit + 1'b1;
                if (q_reg.tx_bit == LAST_BIT) begin
                    q_next.tx_busy = 1'b0;
                end
            end
        end
        q_next.txd_oe = q_next.tx_busy && !q_next.tx_sh[0];
        // echo and store each byte as it leaves the fifo
        if (f_out_valid && f_out_ready) begin
            q_next.ram_we = 1'b1;
            q_next.ram_wdata = f_out_data;
            // own write index: count runs ahead while bytes sit queued
            q_next.ram_addr = q_reg.wr_idx;
            q_next.wr_idx = q_reg.wr_idx + 1'b1;
            q_next.tx_busy = 1'b1;
            q_next.tx_cnt = BIT_C;
            q_next.tx_bit = '0;
            q_next.tx_sh = {1'b1, f_out_data, 1'b0};
            q_next.txd_oe = 1'b1;
        end
        if (f_in_valid) begin
            q_next.count = q_reg.count + 1'b1;
            q_next.overrun = q_reg.overrun || !f_in_ready;
        end
        // idle timer counts whole bit times of a high, quiet line
        if (!q_reg.armed || q_reg.rx_busy || !q_reg.s2) begin
            q_next.idle_cnt = BIT_C;
            q_next.idle_bits = '0;
        end else if (q_reg.idle_cnt != '0) begin
            q_next.idle_cnt = q_reg.idle_cnt - 1'b1;
        end else if (q_reg.idle_bits != IDLE_END) begin
            q_next.idle_cnt = BIT_C;
            q_next.idle_bits = q_reg.idle_bits + 1'b1;
        end
        unique case (q_reg.st)
            sbl_pkg::SBL_BREAK: begin
                // ten low bit times, stop bit included
                q_next.serial_en = 1'b1;
                q_next.tx_busy = 1'b1;
                q_next.tx_cnt = BIT_C;
                q_next.tx_bit = '0;
                q_next.tx_sh = '0;
                q_next.txd_oe = 1'b1;
                q_next.st = sbl_pkg::SBL_WAIT;
            end
            sbl_pkg::SBL_WAIT: begin
                // no timeout here, the host may start whenever it likes
                if (q_reg.rx_valid) begin
                    if (q_reg.rx_data == sbl_pkg::CHAR_ZERO) begin
                        q_next.jump_addr = sbl_pkg::EE_START;
                        q_next.st = sbl_pkg::SBL_JUMP;
                    end else if (q_reg.rx_data == sbl_pkg::CHAR_SYNC) begin
                        q_next.jump_addr = sbl_pkg::RAM_START;
                        q_next.st = sbl_pkg::SBL_JUMP;
                    end else if (q_reg.rx_data == sbl_pkg::CHAR_RATE) begin
                        q_next.armed = 1'b1;
                        q_next.st = sbl_pkg::SBL_LOAD;
                    end
                end
            end
            sbl_pkg::SBL_LOAD: begin
                if (FIXED_LEN && q_reg.count == LEN_C) begin
                    q_next.st = sbl_pkg::SBL_FLUSH;
                end else if (!FIXED_LEN && q_reg.idle_bits == IDLE_END) begin
                    q_next.st = sbl_pkg::SBL_FLUSH;
                end
            end
            sbl_pkg::SBL_FLUSH: begin
                // let the last echoes finish before handing over
                if (!f_out_valid && !q_reg.tx_busy && !q_reg.ram_we) begin
                    q_next.jump_addr = sbl_pkg::RAM_START;
                    q_next.st = sbl_pkg::SBL_JUMP;
                end
            end
            sbl_pkg::SBL_JUMP: begin
                q_next.jump_valid = 1'b1;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            q_reg <= '0;
        end else begin
            q_reg <= q_next;
        end
    end

    // outputs straight from the state register, except txd_out which is tied low
    assign txd_out = 1'b0;
    assign txd_oe = q_reg.txd_oe;
    assign serial_en = q_reg.serial_en;
    assign ram_we = q_reg.ram_we;
    assign ram_addr = q_reg.ram_addr;
    assign ram_wdata = q_reg.ram_wdata;
    assign jump_valid = q_reg.jump_valid;
    assign jump_addr = q_reg.jump_addr;
    assign load_overrun = q_reg.overrun;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    sequence s_first_zero;
        q_reg.st == sbl_pkg::SBL_WAIT && q_reg.rx_valid &&
        q_reg.rx_data == sbl_pkg::CHAR_ZERO;
    endsequence
    sequence s_jump_to(logic [15:0] a);
        ##[1:2] (jump_valid && jump_addr == a);
    endsequence

    chk_zero_jump_ee: assert property (
        s_first_zero |-> s_jump_to(sbl_pkg::EE_START))
        else $error("zero first char did not jump to erasable memory");
    chk_sync_jump_ram: assert property (
        (q_reg.st == sbl_pkg::SBL_WAIT && q_reg.rx_valid &&
         q_reg.rx_data == sbl_pkg::CHAR_SYNC) |->
        s_jump_to(sbl_pkg::RAM_START))
        else $error("sync char did not jump to ram");
    chk_idle_end_load: assert property (
        (q_reg.st == sbl_pkg::SBL_LOAD && !FIXED_LEN &&
         q_reg.idle_bits == IDLE_END) |=> q_reg.st == sbl_pkg::SBL_FLUSH)
        else $error("idle line did not end the download");
    chk_wait_forever: assert property (
        (q_reg.st == sbl_pkg::SBL_WAIT && !q_reg.rx_valid) |=>
        (q_reg.st == sbl_pkg::SBL_WAIT && q_reg.idle_bits == '0))
        else $error("left wait or timed out without a char");
    chk_edge_start: assert property (
        (!q_reg.rx_busy && !q_reg.high) |=> !q_reg.rx_busy)
        else $error("receiver started without a falling edge");
    chk_break_sent: assert property (
        q_reg.st == sbl_pkg::SBL_WAIT && $past(q_reg.st) ==
        sbl_pkg::SBL_BREAK |-> (txd_oe && q_reg.tx_sh == '0))
        else $error("break not started at boot");
    chk_open_drain: assert property (
        q_reg.tx_busy |-> (txd_oe == !q_reg.tx_sh[0] && !txd_out))
        else $error("transmit pin driven high or wrong level");
    chk_serial_on: assert property (
        q_reg.st != sbl_pkg::SBL_BREAK |-> serial_en)
        else $error("serial unit not enabled");
    chk_echo_each: assert property (
        (f_out_valid && f_out_ready) |=>
        (ram_we && q_reg.tx_busy && q_reg.tx_sh[8:1] == ram_wdata))
        else $error("stored byte was not echoed");
    chk_ram_limit: assert property (
        ram_we |-> ram_addr < RAM_C)
        else $error("write past ram limit");
    chk_fixed_count: assert property (
        (FIXED_LEN && q_reg.st == sbl_pkg::SBL_LOAD && q_reg.count == LEN_C)
        |=> q_reg.st == sbl_pkg::SBL_FLUSH)
        else $error("fixed download did not stop at its length");
    chk_done_jump: assert property (
        (q_reg.st == sbl_pkg::SBL_FLUSH && !f_out_valid && !q_reg.tx_busy &&
         !q_reg.ram_we) |-> s_jump_to(sbl_pkg::RAM_START))
        else $error("finished download did not jump to ram");
endmodule // sbl_boot_loader
`default_nettype wire

/* File: dv/sbl_host_model.sv */
// host side of the boot link: sends characters and collects echoes
`timescale 1ns/10ps
`default_nettype none
module sbl_host_model #(
    parameter int BIT = 16
) (
    // clock
    input wire logic ref_clk,
    // link lines
    input wire logic txd_line,
    output logic host_tx
);
    logic [7:0] echo_q[$];
    logic [7:0] shift_reg;

    // idle line is high, as a real host leaves it
    initial begin
        host_tx = 1'b1;
    end

    // drive the receive line to a level from the next falling edge
    task automatic set_line(input logic v);
        @(negedge ref_clk);
        host_tx = v;
    endtask

    // one 8N1 character at the default rate, lsb first, no gap after it;
    // a zero byte with stop low makes a line break
    task automatic send_byte(input logic [7:0] b, input logic stop);
        logic [9:0] frame;
        frame = {stop, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(negedge ref_clk);
            host_tx = frame[i];
            repeat (BIT - 1) @(negedge ref_clk);
        end
    endtask

    // echo receiver: start only after the pulled-up line was high
    always begin
        @(posedge ref_clk iff txd_line === 1'b1);
        @(posedge ref_clk iff txd_line === 1'b0);
        repeat (BIT / 2) @(posedge ref_clk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT) @(posedge ref_clk);
            shift_reg = {txd_line, shift_reg[7:1]};
        end
        repeat (BIT) @(posedge ref_clk);
        echo_q.push_back(shift_reg);
    end
endmodule // sbl_host_model
`default_nettype wire

/* File: dv/tb_top.sv */
// self-checking bench for the serial boot loader
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    // short bit time keeps the 40-bit idle detect quick
    localparam int BIT = 16;
    localparam int RAM_LIM = 4;
    logic ref_clk, reset_n, loop_en, host_tx, rxd_in, txd_line;
    logic txd_out, txd_oe, serial_en, ram_we, jump_valid, fx_jump;
    logic [sbl_pkg::ADDR_W-1:0] ram_addr;
    logic [7:0] ram_wdata;
    logic [15:0] jump_addr;
    logic load_overrun;
    int bad_count, cmp_count;
    logic [7:0] wr_data_q[$];
    logic [sbl_pkg::ADDR_W-1:0] wr_addr_q[$];

    // ************************************************************
    // wiring and instances
    // ************************************************************
    // open-drain transmit with pull-up; loopback feeds it to receive
    assign txd_line = txd_oe ? txd_out : 1'b1;
    assign rxd_in = loop_en ? txd_line : host_tx;

    sbl_boot_loader #(.BIT_CYCLES(BIT),
        .RAM_BYTES(RAM_LIM)) sbl_boot_loader_i (.ref_clk(ref_clk),
        .reset_n(reset_n), .rxd_in(rxd_in), .txd_out(txd_out),
        .txd_oe(txd_oe), .serial_en(serial_en), .ram_we(ram_we),
        .ram_addr(ram_addr), .ram_wdata(ram_wdata),
        .jump_valid(jump_valid), .jump_addr(jump_addr),
        .load_overrun(load_overrun));
    // fixed-length twin listens to the same host; its transmit outputs are left unconnected
    sbl_boot_loader #(.BIT_CYCLES(BIT), .FIXED_LEN(1'b1),
        .LOAD_LEN(4)) sbl_boot_loader_fixed_i (.ref_clk(ref_clk),
        .reset_n(reset_n), .rxd_in(rxd_in), .txd_out(), .txd_oe(),
        .serial_en(), .ram_we(), .ram_addr(), .ram_wdata(),
        .jump_valid(fx_jump), .jump_addr(), .load_overrun());
    sbl_host_model #(.BIT(BIT)) sbl_host_model_i (.ref_clk(ref_clk),
        .txd_line(txd_line), .host_tx(host_tx));

    // clock
    always #2 ref_clk = ~ref_clk;

    // ram write log, cleared at each reset, read by the first, load and buffer tests
    always @(posedge ref_clk) begin
        if (ram_we === 1'b1) begin
            wr_data_q.push_back(ram_wdata);
            wr_addr_q.push_back(ram_addr);
        end
    end

    // ************************************************************
    // shared tasks
    // ************************************************************
    task automatic check(input string name, input logic [15:0] seen,
                         input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic do_reset(input logic loop, input logic line);
        sbl_host_model_i.set_line(line);
        reset_n = 1'b0;
        loop_en = loop;
        repeat (2) @(negedge ref_clk);
        reset_n = 1'b1;
        wr_data_q.delete();
        wr_addr_q.delete();
    endtask

    // bounded wait for the jump request
    task automatic wait_jump(input int lim, output logic hit);
        hit = 1'b0;
        for (int i = 0; i < lim && hit !== 1'b1; i++) begin
            @(negedge ref_clk);
            hit = jump_valid;
        end
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_break();
        int n;
        int hi;
        n = 0;
        hi = 0;
        do_reset(1'b0, 1'b1);
        // break starts at the first edge after release
        @(negedge ref_clk);
        check("serial_en", serial_en, 1'b1);
        check("break_start", txd_oe, 1'b1);
        while (txd_oe === 1'b1 && n < 400) begin
            if (txd_out !== 1'b0) hi++;
            n++;
            @(negedge ref_clk);
        end
        check("break_len", n, 10 * BIT);
        check("never_high", hi, 0);
        $display("test break done");
    endtask

    // loopback break, host break, zero byte and sync byte
    task automatic t_first();
        logic [7:0] ch[4] = '{8'h00, 8'h00, 8'h00, sbl_pkg::CHAR_SYNC};
        logic st[4] = '{1'b1, 1'b0, 1'b1, 1'b1};
        logic [15:0] dst[4] = '{sbl_pkg::EE_START, sbl_pkg::EE_START,
            sbl_pkg::EE_START, sbl_pkg::RAM_START};
        logic hit;
        for (int k = 0; k < 4; k++) begin
            do_reset(k == 0, 1'b1);
            if (k > 0) sbl_host_model_i.send_byte(ch[k], st[k]);
            sbl_host_model_i.set_line(1'b1);
            wait_jump(20 * BIT, hit);
            check("first_jump", hit, 1'b1);
            check("first_addr", jump_addr, dst[k]);
            check("no_write", wr_addr_q.size(), 0);
        end
        $display("test first character done");
    endtask

    task automatic t_idle();
        logic hit;
        do_reset(1'b0, 1'b0);
        wait_jump(60 * BIT, hit);
        check("low_line", hit, 1'b0);
        sbl_host_model_i.set_line(1'b1);
        wait_jump(100 * BIT, hit);
        check("wait_unarmed", hit, 1'b0);
        sbl_host_model_i.send_byte(sbl_pkg::CHAR_RATE, 1'b1);
        wait_jump(38 * BIT, hit);
        check("idle_early", hit, 1'b0);
        wait_jump(10 * BIT, hit);
        check("rate_only", hit, 1'b1);
        check("rate_addr", jump_addr, sbl_pkg::RAM_START);
        $display("test idle end done");
    endtask

    // five data bytes back to back; ram holds four, fixed twin takes four
    task automatic t_load();
        logic [7:0] d[5] = '{8'hA5, 8'h3C, 8'h00, 8'hFF, 8'h5A};
        logic hit;
        do_reset(1'b0, 1'b1);
        repeat (12 * BIT) @(negedge ref_clk);
        sbl_host_model_i.echo_q.delete();
        sbl_host_model_i.send_byte(sbl_pkg::CHAR_RATE, 1'b1);
        for (int i = 0; i < 5; i++) sbl_host_model_i.send_byte(d[i], 1'b1);
        repeat (2 * BIT) @(negedge ref_clk);
        check("fixed_done", fx_jump, 1'b1);
        check("var_pending", jump_valid, 1'b0);
        wait_jump(50 * BIT, hit);
        check("load_jump", hit, 1'b1);
        check("load_addr", jump_addr, sbl_pkg::RAM_START);
        check("writes", wr_addr_q.size(), RAM_LIM);
        for (int i = 0; i < RAM_LIM; i++) begin
            check("wr_addr", wr_addr_q[i], i);
            check("wr_data", wr_data_q[i], d[i]);
            check("echo", sbl_host_model_i.echo_q[i], d[i]);
        end
        $display("test load done");
    endtask

    // three bytes through the receive buffer, in order, none dropped
    task automatic t_fifo();
        logic hit;
        do_reset(1'b0, 1'b1);
        repeat (12 * BIT) @(negedge ref_clk);
        sbl_host_model_i.echo_q.delete();
        sbl_host_model_i.send_byte(sbl_pkg::CHAR_RATE, 1'b1);
        for (int i = 0; i < 3; i++) begin
            sbl_host_model_i.send_byte(8'(8'hC0 + i), 1'b1);
        end
        wait_jump(60 * BIT, hit);
        check("fifo_jump", hit, 1'b1);
        check("fifo_overrun", load_overrun, 1'b0);
        check("fifo_echoes", sbl_host_model_i.echo_q.size(), 3);
        check("fifo_writes", wr_addr_q.size(), 3);
        for (int i = 0; i < 3; i++) begin
            check("fifo_data", sbl_host_model_i.echo_q[i], 8'hC0 + i);
            check("fifo_addr", wr_addr_q[i], i);
            check("fifo_wdata", wr_data_q[i], 8'hC0 + i);
        end
        $display("test buffer done");
    endtask

    // ************************************************************
    // main sequence and watchdog
    // ************************************************************
    initial begin
        ref_clk = 1'b0;
        reset_n = 1'b0;
        loop_en = 1'b0;
        bad_count = 0;
        cmp_count = 0;
        repeat (2) @(negedge ref_clk);
        reset_n = 1'b1;
        t_break();
        t_first();
        t_idle();
        t_load();
        t_fifo();
        print_verdict();
    end

    // the tests need about 8000 cycles; this allows six times that
    initial begin
        #200000;
        bad_count++;
        $display("watchdog expired");
        print_verdict();
    end
endmodule // tb_top
`default_nettype wire
